// ==== common/ebrw_map.svh ====
// offsets, field positions, reset values and timing counts of the wait logic
`ifndef EBRW_MAP_SVH
`define EBRW_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define EBRW_REG_CFG        8'h00
`define EBRW_REG_STAT       8'h04
`define EBRW_REG_WCNT       8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EBRW_CFG_POL_BIT    0
`define EBRW_CFG_ASYNC_BIT  1
`define EBRW_CFG_CLKEN_BIT  2
`define EBRW_STAT_BUSY_BIT  0
`define EBRW_STAT_RDY_BIT   1
`define EBRW_STAT_ST_LSB    2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EBRW_CFG_RESET      3'h4
`define EBRW_WCNT_RESET     16'h0000

// ----------------------------------------------------------------
// timing: one clk_in cycle is one half bus clock period
// ----------------------------------------------------------------
`define EBRW_CLK_PERIOD_PS  4000
`define EBRW_HALF_PERIOD_PS 4000
`define EBRW_TICKS_PER_HALF \
  ((`EBRW_HALF_PERIOD_PS + `EBRW_CLK_PERIOD_PS - 1) / `EBRW_CLK_PERIOD_PS)
`define EBRW_BUS_CYCLE_TICKS (2 * `EBRW_TICKS_PER_HALF)
`define EBRW_ARDY_EXTRA_NS  7
`define EBRW_ARDY_MIN_PS \
  (2 * `EBRW_HALF_PERIOD_PS + `EBRW_ARDY_EXTRA_NS * 1000)
`define EBRW_ARDY_MIN_TICKS \
  ((`EBRW_ARDY_MIN_PS + `EBRW_CLK_PERIOD_PS - 1) / `EBRW_CLK_PERIOD_PS)

`endif

// ==== common/ebrw_pkg.sv ====
// types shared by the external bus ready and wait state logic
package ebrw_pkg;

  // one-hot bus cycle states
  typedef enum logic [6:0] {
    EBRW_IDLE = 7'h01,
    EBRW_INS  = 7'h02,
    EBRW_ADDR = 7'h04,
    EBRW_CMD  = 7'h08,
    EBRW_WAIT = 7'h10,
    EBRW_MUXW = 7'h20,
    EBRW_TRI  = 7'h40
  } ebrw_state_t;

  // one external cycle request
  typedef struct packed {
    logic       write;
    logic       mux_mode;
    logic       rw_delay;
    logic       tristate_turnaround_wait;
    logic [3:0] memory_cycle_wait_count;
  } ebrw_req_t;

  // strobes towards the pins
  typedef struct packed {
    logic ale;
    logic rd_n;
    logic wr_n;
  } ebrw_pins_t;

endpackage

// ==== hdl/ebrw_ctrl.sv ====
// external bus cycle length, ready wait states and turnaround gaps
//
// How it works
// [RQ1] programmed length with memory cycle waits runs before ready sampling
// [RQ2] rw delay moves command strobe leading edge one half period later
// [RQ3] inactive ready at sampling point adds one ready wait state
// [RQ4] active ready at sampling point ends the running cycle
// [RQ5] responder may drop ready on the command trailing edge
// [RQ6] unaligned async ready stays active two half periods plus 7 ns
// [RQ7] dropping ready on command end guarantees that minimum
// [RQ8] multiplexed cycles append turnaround wait, optional tristate wait
// [RQ9] gap is two bus clocks muxed with tristate, zero demuxed without
// [RQ10] ready sampled synchronously to bus clock or through a synchronizer; sync mode samples on link_clk_in, then two clk_in flops
// [RQ11] demux to mux change inserts one idle state of two half periods
// [RQ12] each ready wait state adds one bus clock, ready resampled after
// [RQ13] async ready passes two flops on the cpu clock before use
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "ebrw_map.svh"

module ebrw_ctrl #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // cpu clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  // responder clock for synchronous ready
  input  wire logic               link_clk_in,
  // register port
  input  wire logic [ADDR_W-1:0]  reg_addr_in,
  input  wire logic [DATA_W-1:0]  reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output      logic [DATA_W-1:0]  reg_rdata_out,
  // cycle requests from the bus controller
  input  wire logic               req_valid_in,
  input  wire ebrw_pkg::ebrw_req_t req_in,
  output      logic               req_ready_out,
  output      logic               cycle_done_out,
  // external pins
  input  wire logic               ready_pin_in,
  output      ebrw_pkg::ebrw_pins_t pins_out,
  output      logic               bus_clock_output_out
);
  import ebrw_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ebrw_state_t       state_ff;
  ebrw_state_t       nxt_state;
  ebrw_req_t         req_ff;
  logic [5:0]        cnt_ff;
  logic [5:0]        nxt_cnt;
  logic              prev_mux_ff;
  logic              first_cmd_ff;
  logic [2:0]        cfg_ff;
  logic [15:0]       wcnt_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              bclk_ff;
  logic              ale_ff;
  logic              strobe_ff;
  logic              done_ff;
  logic              link_rdy_ff;
  logic              lsync1_ff;
  logic              lsync2_ff;
  logic              async1_ff;
  logic              async2_ff;
  logic              ready_level;
  logic              ready_active;
  logic              accept;
  logic              count_end;
  logic              sample_pt;
  logic              cycle_end;
  logic              wait_ins;
  logic [5:0]        cmd_ticks;

  localparam logic [5:0] BUS_TICKS = 6'(`EBRW_BUS_CYCLE_TICKS);
  localparam logic [5:0] HALF_TICKS = 6'(`EBRW_TICKS_PER_HALF);

  // ----------------------------------------------------------------
  // ready capture and crossing
  // ----------------------------------------------------------------

  // synchronous ready taken on the responder clock edge
  always_ff @(posedge link_clk_in) begin
    link_rdy_ff <= ready_pin_in;
  end

  // level crossing of the link sample into the cpu domain
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      lsync1_ff <= 1'b0;
      lsync2_ff <= 1'b0;
    end else begin
      lsync1_ff <= link_rdy_ff;
      lsync2_ff <= lsync1_ff;
    end
  end

  // two flop synchronizer for asynchronous ready
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      async1_ff <= 1'b0;
      async2_ff <= 1'b0;
    end else begin
      async1_ff <= ready_pin_in;  // RQ13
      async2_ff <= async1_ff;     // RQ13
    end
  end

  // mode and polarity select; only second flops are read
  always_comb begin
    ready_level = cfg_ff[`EBRW_CFG_ASYNC_BIT] ? async2_ff
                                              : lsync2_ff;  // RQ10
    ready_active = cfg_ff[`EBRW_CFG_POL_BIT] ? ready_level
                                             : ~ready_level;  // RQ3
  end

  // ----------------------------------------------------------------
  // cycle sequencing
  // ----------------------------------------------------------------

  // decode of handshake and sampling moments
  assign accept    = req_valid_in & (state_ff == EBRW_IDLE);
  assign count_end = (cnt_ff == 6'h00);
  assign sample_pt = count_end &
                     ((state_ff == EBRW_CMD) | (state_ff == EBRW_WAIT));
  assign cycle_end = sample_pt & ready_active;   // RQ4
  assign wait_ins  = sample_pt & ~ready_active;  // RQ3
  assign cmd_ticks = 6'(BUS_TICKS +
                        BUS_TICKS * 6'(req_ff.memory_cycle_wait_count));

  // next state and counter
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = count_end ? 6'h00 : 6'(cnt_ff - 6'h01);
    case (state_ff)
      EBRW_IDLE: begin
        if (accept) begin
          if (req_in.mux_mode && !prev_mux_ff) begin
            nxt_state = EBRW_INS;  // RQ11
          end else begin
            nxt_state = EBRW_ADDR;
          end
          nxt_cnt = 6'(BUS_TICKS - 6'h01);
        end
      end
      EBRW_INS: begin
        if (count_end) begin
          nxt_state = EBRW_ADDR;
          nxt_cnt   = 6'(BUS_TICKS - 6'h01);
        end
      end
      EBRW_ADDR: begin
        if (count_end) begin
          nxt_state = EBRW_CMD;
          nxt_cnt   = 6'(cmd_ticks - 6'h01);  // RQ1
        end
      end
      EBRW_CMD, EBRW_WAIT: begin
        if (wait_ins) begin
          nxt_state = EBRW_WAIT;              // RQ12
          nxt_cnt   = 6'(BUS_TICKS - 6'h01);  // RQ12
        end else if (cycle_end) begin
          nxt_cnt = 6'(BUS_TICKS - 6'h01);
          if (req_ff.mux_mode) begin
            nxt_state = EBRW_MUXW;  // RQ8
          end else if (req_ff.tristate_turnaround_wait) begin
            nxt_state = EBRW_TRI;
          end else begin
            nxt_state = EBRW_IDLE;  // RQ9
          end
        end
      end
      EBRW_MUXW: begin
        if (count_end) begin
          if (req_ff.tristate_turnaround_wait) begin
            nxt_state = EBRW_TRI;  // RQ8
            nxt_cnt   = 6'(BUS_TICKS - 6'h01);
          end else begin
            nxt_state = EBRW_IDLE;
          end
        end
      end
      EBRW_TRI: begin
        if (count_end) begin
          nxt_state = EBRW_IDLE;  // RQ9
        end
      end
      default: begin
        nxt_state = EBRW_IDLE;
        nxt_cnt   = 6'h00;
      end
    endcase
  end

  // state and tick counter
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= EBRW_IDLE;
      cnt_ff   <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // request latch and bus mode history
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      req_ff      <= '0;
      prev_mux_ff <= 1'b1;
    end else if (accept) begin
      req_ff      <= req_in;
      prev_mux_ff <= req_in.mux_mode;
    end
  end

  // ----------------------------------------------------------------
  // pin strobes
  // ----------------------------------------------------------------

  // address latch enable during the address phase
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ale_ff <= 1'b0;
    end else begin
      ale_ff <= (nxt_state == EBRW_ADDR);
    end
  end

  // command strobe, optionally delayed by one half period
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      strobe_ff    <= 1'b0;
      first_cmd_ff <= 1'b0;
    end else begin
      first_cmd_ff <= 1'b0;
      if (state_ff == EBRW_ADDR && count_end) begin
        strobe_ff    <= ~req_ff.rw_delay;  // RQ2
        first_cmd_ff <= req_ff.rw_delay;
      end else if (first_cmd_ff) begin
        strobe_ff <= 1'b1;                 // RQ2
      end else if (cycle_end) begin
        strobe_ff <= 1'b0;                 // RQ4
      end
    end
  end

  // one cycle completion pulse
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= cycle_end;
    end
  end

  // bus clock output: two half periods per period
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bclk_ff <= 1'b0;
    end else if (cnt_ff[0] == 1'b0 || HALF_TICKS == 6'h01) begin
      bclk_ff <= ~bclk_ff;
    end
  end

  assign pins_out.ale  = ale_ff;
  assign pins_out.rd_n = ~(strobe_ff & ~req_ff.write);
  assign pins_out.wr_n = ~(strobe_ff & req_ff.write);
  assign bus_clock_output_out = bclk_ff & cfg_ff[`EBRW_CFG_CLKEN_BIT];
  assign req_ready_out  = (state_ff == EBRW_IDLE);
  assign cycle_done_out = done_ff;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // configuration: polarity, async mode, bus clock enable
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cfg_ff <= `EBRW_CFG_RESET;
    end else if (reg_wr_in && reg_addr_in == `EBRW_REG_CFG) begin
      cfg_ff <= reg_wdata_in[2:0];
    end
  end

  // count of ready wait states; hardware increment beats clear
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wcnt_ff <= `EBRW_WCNT_RESET;
    end else if (wait_ins) begin
      wcnt_ff <= 16'(wcnt_ff + 16'h0001);
    end else if (reg_wr_in && reg_addr_in == `EBRW_REG_WCNT) begin
      wcnt_ff <= `EBRW_WCNT_RESET;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= '0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `EBRW_REG_CFG: begin
            rdata_ff <= DATA_W'(cfg_ff);
          end
          `EBRW_REG_STAT: begin
            rdata_ff <= DATA_W'({state_ff, ready_active,
                                 ~req_ready_out});
          end
          `EBRW_REG_WCNT: begin
            rdata_ff <= DATA_W'(wcnt_ff);
          end
          default: begin
            rdata_ff <= '0;
          end
        endcase
      end
    end
  end

  assign reg_rdata_out = rdata_ff;

endmodule

// ==== sim/ebrw_ctrl_checker.sv ====
// port checks of the external bus wait logic
`timescale 1ns/1ps
module ebrw_chk (
  // clock and reset
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  // register and request side
  input wire logic                 reg_rd_in,
  input wire logic [31:0]          reg_rdata_out,
  input wire logic                 req_valid_in,
  input wire logic                 req_ready_out,
  input wire logic                 cycle_done_out,
  // pins
  input wire ebrw_pkg::ebrw_pins_t pins_out,
  input wire logic                 bus_clock_output_out
);
  import ebrw_pkg::*;
  logic cmd;
  // any command strobe low
  assign cmd = !pins_out.rd_n || !pins_out.wr_n;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // -----------------------------------------
  // cycle shape, bus clock and idle read data
  // -----------------------------------------
  chk_ale_width: assert property (
    $rose(pins_out.ale) |=> pins_out.ale ##1 !pins_out.ale)
    else $error("ale width");
  chk_cmd_follows: assert property (
    $fell(pins_out.ale) |-> ##[0:1] cmd)
    else $error("command late");
  chk_done_end: assert property (
    cycle_done_out |-> $rose(pins_out.rd_n) || $rose(pins_out.wr_n))
    else $error("done without strobe end");
  chk_done_pulse: assert property (
    cycle_done_out |=> !cycle_done_out)
    else $error("done too long");
  chk_busy_refuse: assert property (
    cmd |-> !req_ready_out)
    else $error("ready while busy");
  chk_take_ale: assert property (
    req_valid_in && req_ready_out |-> ##[1:3] pins_out.ale)
    else $error("no ale after take");
  chk_clk_period: assert property (
    $rose(bus_clock_output_out) |=> $fell(bus_clock_output_out))
    else $error("bus clock period");
  chk_rdata_idle: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data not idle");
endmodule

bind ebrw_ctrl ebrw_chk u_chk (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .req_valid_in(req_valid_in),
  .req_ready_out(req_ready_out),
  .cycle_done_out(cycle_done_out),
  .pins_out(pins_out),
  .bus_clock_output_out(bus_clock_output_out)
);

// ==== sim/ebrw_resp_model.sv ====
// responder model driving the ready pin
`timescale 1ns/1ps
module ebrw_resp_model (
  // clock and setup
  input  wire logic                 clk_in,
  input  wire logic                 pol_in,
  input  wire logic [3:0]           slow_in,
  // bus side
  input  wire ebrw_pkg::ebrw_pins_t pins_in,
  output      logic                 ready_pin_out
);
  import ebrw_pkg::*;
  logic [3:0] hold_ff = 4'h0;
  logic       cmd_ff  = 1'b0;
  logic       cmd;
  logic       act;
  assign cmd = !pins_in.rd_n || !pins_in.wr_n;
  // slow mode: hold ready off for slow_in plus one ticks of the command
  always_ff @(posedge clk_in) begin
    cmd_ff <= cmd;
    if (cmd && !cmd_ff) begin
      hold_ff <= slow_in;
    end else if (hold_ff != 4'h0) begin
      hold_ff <= hold_ff - 4'h1;
    end
  end
  // withdrawn only at the strobe end, so it stays long enough
  assign act = (slow_in == 4'h0) ||
               (cmd && cmd_ff && hold_ff == 4'h0);
  assign ready_pin_out = act ~^ pol_in;
endmodule

// ==== sim/tb_external_bus_ready_waitstate.sv ====
// bench for the external bus ready and wait state logic
`timescale 1ns/1ps
`include "ebrw_map.svh"
module tb_external_bus_ready_waitstate;
  import ebrw_pkg::*;
  logic        clk_in, rst_n_in, link_clk_in, reg_wr_in, reg_rd_in;
  logic        req_valid_in, req_ready_out, cycle_done_out;
  logic        ready_pin_in, bus_clock_output_out, pol;
  logic [7:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [3:0]  slow;
  ebrw_req_t   req_in;
  ebrw_pins_t  pins_out;
  int          err_count, num_checks;

  // clocks, link clock unrelated in phase
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #1.3;
    forever #3 link_clk_in = ~link_clk_in;
  end

  ebrw_ctrl DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .link_clk_in(link_clk_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .cycle_done_out(cycle_done_out),
    .ready_pin_in(ready_pin_in), .pins_out(pins_out),
    .bus_clock_output_out(bus_clock_output_out));
  ebrw_resp_model u_resp (.clk_in(clk_in), .pol_in(pol),
    .slow_in(slow), .pins_in(pins_out), .ready_pin_out(ready_pin_in));

  // -----------------------------------------
  // shared tasks
  // -----------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    @(negedge clk_in);
    d = reg_rdata_out;
  endtask
  // one bus cycle: length, strobe time, waits and gap after it
  task automatic cyc(logic [7:0] r, int d, int ins);
    int          n, lo, g, bad;
    logic [31:0] w;
    ebrw_req_t   q;
    q = r;
    slow <= d[3:0];
    @(posedge clk_in);
    req_in       <= q;
    req_valid_in <= 1'b1;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    n = 0;
    lo = 0;
    bad = 0;
    do begin
      @(negedge clk_in);
      n++;
      if (!pins_out.rd_n || !pins_out.wr_n) lo++;
      if (q.write ? !pins_out.rd_n : !pins_out.wr_n) bad++;
    end while (cycle_done_out !== 1'b1 && n < 100);
    g = 0;
    while (req_ready_out !== 1'b1 && g < 20) begin
      g++;
      @(negedge clk_in);
    end
    rd(`EBRW_REG_WCNT, w);
    wr(`EBRW_REG_WCNT, 32'h0000_0000);
    chk("waits", {31'h0, d != 0}, {31'h0, w != 0});
    chk("length", 5 + 2 * q.memory_cycle_wait_count +
        2 * ins + 2 * w, n);
    chk("strobe", 2 + 2 * q.memory_cycle_wait_count -
        q.rw_delay + 2 * w, lo);
    chk("strobe kind", 32'h0000_0000, bad);
    chk("gap", 2 * q.mux_mode + 2 * q.tristate_turnaround_wait, g);
  endtask

  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  task automatic t_regs();
    logic [31:0] v;
    rd(`EBRW_REG_CFG, v);
    chk("cfg reset", 32'h0000_0004, v);
    rd(`EBRW_REG_STAT, v);
    chk("stat idle", 32'h0000_0006, v);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, v);
    chk("unmapped", 32'h0000_0000, v);
    rd(`EBRW_REG_CFG, v);
    chk("cfg kept", 32'h0000_0004, v);
    $display("test regs done");
  endtask
  task automatic t_length();
    for (int k = 0; k < 4; k++) cyc(8'(k), 0, 0);
    cyc(8'hA1, 0, 0);
    cyc(8'hA0, 0, 0);
    $display("test length done");
  endtask
  task automatic t_ready();
    cyc(8'h00, 6, 0);
    wr(`EBRW_REG_CFG, 32'h0000_0006);
    cyc(8'h01, 0, 0);
    cyc(8'h00, 7, 0);
    wr(`EBRW_REG_CFG, 32'h0000_0007);
    pol <= 1'b1;
    cyc(8'h80, 0, 0);
    cyc(8'h80, 5, 0);
    wr(`EBRW_REG_CFG, 32'h0000_0005);
    cyc(8'h02, 6, 0);
    $display("test ready done");
  endtask
  task automatic t_mux();
    cyc(8'h40, 0, 1);
    cyc(8'h50, 0, 0);
    cyc(8'h10, 0, 0);
    cyc(8'h41, 3, 1);
    $display("test mux done");
  endtask
  // reset in the middle of a command, then a clean cycle
  task automatic t_reset();
    logic [31:0] v;
    pol  <= 1'b0;
    slow <= 4'h0;
    @(posedge clk_in);
    req_in       <= 8'h03;
    req_valid_in <= 1'b1;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    chk("reset pins", 32'h0000_0003, {29'h0, pins_out});
    chk("reset ready", 32'h0000_0001, {31'h0, req_ready_out});
    rd(`EBRW_REG_CFG, v);
    chk("reset cfg", 32'h0000_0004, v);
    cyc(8'h00, 0, 0);
    $display("test reset done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog well past the expected run
  initial begin
    #60000;
    err_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    rst_n_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0000_0000;
    req_valid_in = 1'b0;
    req_in = 8'h00;
    pol = 1'b0;
    slow = 4'h0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_length();
    t_ready();
    t_mux();
    t_reset();
    end_of_test();
  end
endmodule
